// >>> jesd_link_param_regs_tb.sv
`timescale 1ns/100ps
module jesd_link_param_regs_tb;
    import jlp_pkg::*;
    logic        sys_clk, reset_n;          // clock, async reset
    logic [3:0]  awaddr, araddr, wstrb;     // axi address, strobes
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;              // axi data
    logic [1:0]  bresp, rresp;              // axi responses
    logic [4:0]  cfg_k;                     // frames per multiframe out
    logic [2:0]  cfg_sub, cfg_ver;          // subclass, version out
    logic        rx_sr;                     // receiver held
    int          errors, cmp_count, cyc;    // counters

    jlp_reg_if u_jlp_reg_if ();
    jlp_device u_jlp_device (.sys_clk(sys_clk), .reset_n(reset_n),
        .bus(u_jlp_reg_if), .cfg_frames_per_multiframe(cfg_k),
        .cfg_subclass(cfg_sub), .cfg_version(cfg_ver),
        .rx_soft_reset(rx_sr));
    jlp_host u_jlp_host (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus(u_jlp_reg_if));
    jlp_reg_sva u_jlp_reg_sva (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(u_jlp_reg_if.reg_addr), .reg_wr(u_jlp_reg_if.reg_wr),
        .reg_rd(u_jlp_reg_if.reg_rd), .reg_wdata(u_jlp_reg_if.reg_wdata),
        .reg_rdata(u_jlp_reg_if.reg_rdata), .reg_ack(u_jlp_reg_if.reg_ack));

    // clock generator
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // handshakes judged on the falling edge
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic ah, wh, bh, done;
        logic [1:0] br;
        done = 1'b0;
        @(posedge sys_clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk);
            ah = awvalid && awready; wh = wvalid && wready;
            bh = bvalid && bready; br = bresp;
            @(posedge sys_clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) begin bready <= 1'b0; done = 1'b1; end
        end
        chk(32'(br), 32'(RESP_OKAY));
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic ah, rh, done;
        done = 1'b0;
        @(posedge sys_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk);
            ah = arvalid && arready; rh = rvalid && rready;
            d = rdata; r = rresp;
            @(posedge sys_clk);
            if (ah) arvalid <= 1'b0;
            if (rh) begin rready <= 1'b0; done = 1'b1; end
        end
    endtask
    // bank access, refused flag cleared after
    task automatic bank(input logic [11:0] ofs, input logic [7:0] b,
                        input logic rd, output logic [31:0] st);
        logic [1:0] r;
        axi_wr(H_TARGET, 32'(ofs));
        axi_wr(H_WDATA, 32'(b));
        axi_wr(H_GO, rd ? 32'h2 : 32'h1);
        do axi_rd(H_STATUS, st, r); while (st[ST_BUSY_BIT] !== 1'b0);
        axi_wr(H_STATUS, 32'h2);
    endtask
    task automatic t_resets();
        logic [7:0] e [7] = '{8'h07, 8'h00, 8'h1f, 8'h01, 8'h0f, 8'h0f, 8'h01};
        logic [31:0] st;
        for (int i = 0; i < 7; i++) begin
            bank(OFS_LANES + 12'(i), 8'h00, 1'b1, st);
            chk(st >> 8, 32'(e[i]));
        end
    endtask
    // read-only refuses even in soft reset
    task automatic t_read_only();
        logic [31:0] st;
        bank(OFS_SOFT_RESET, 8'h08, 1'b0, st);
        bank(OFS_OCTETS, 8'h05, 1'b0, st);
        chk(32'(st[ST_REFUSED_BIT]), 32'h1);
        bank(OFS_OCTETS, 8'h00, 1'b1, st);
        chk(st >> 8, 32'h00);
        bank(OFS_SOFT_RESET, 8'h00, 1'b0, st);
    endtask
    task automatic t_gate();
        logic [31:0] st;
        bank(OFS_FRAMES, 8'h0f, 1'b0, st);
        chk(32'(st[ST_REFUSED_BIT]), 32'h1);
        chk(32'(cfg_k), 32'h1f);
        bank(OFS_SOFT_RESET, 8'h08, 1'b0, st);
        chk(32'(rx_sr), 32'h1);
        bank(OFS_FRAMES, 8'h0f, 1'b0, st);
        bank(OFS_FRAMES, 8'h00, 1'b1, st);
        chk(st >> 8, 32'h0f);
        chk(32'(cfg_k), 32'h0f);
        bank(OFS_FRAMES, 8'h10, 1'b0, st);
        chk(32'(st[ST_REFUSED_BIT]), 32'h1);
        chk(32'(cfg_k), 32'h0f);
    endtask
    // legal codes, then subclass 2
    task automatic t_codes();
        logic [31:0] st;
        for (int i = 0; i < 2; i++) begin
            bank(OFS_SUB_NP, {3'(i), 5'h0f}, 1'b0, st);
            chk(32'(cfg_sub), 32'(i));
            bank(OFS_VER_SAMPLES, {3'(i), 5'h01}, 1'b0, st);
            bank(OFS_VER_SAMPLES, 8'h00, 1'b1, st);
            chk(st >> 8, 32'({3'(i), 5'h01}));
            chk(32'(cfg_ver), 32'(i));
        end
        bank(OFS_SUB_NP, 8'h4f, 1'b0, st);
        chk(32'(st[ST_REFUSED_BIT]), 32'h1);
        bank(OFS_SUB_NP, 8'h00, 1'b1, st);
        chk(st >> 8, 32'h2f);
        bank(OFS_SOFT_RESET, 8'h00, 1'b0, st);
    endtask
    // unmapped controller word
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(4'h6, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // reset, then scenarios
    initial begin
        errors = 0; cmp_count = 0; cyc = 0; reset_n = 1'b0;
        awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = 4'hf;
        wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0;
        rready = 1'b0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_resets();
        t_read_only();
        t_gate();
        t_codes();
        t_unmapped();
        wrap_up();
    end
endmodule

// >>> jlp_device.sv
`timescale 1ns/100ps
// link parameter bank of the receiver
module jlp_device (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    jlp_reg_if.dev          bus,
    output logic [4:0]      cfg_frames_per_multiframe,
    output logic [2:0]      cfg_subclass,
    output logic [2:0]      cfg_version,
    output logic            rx_soft_reset
);
    import jlp_pkg::*;

    // whole state of the bank
    typedef struct packed {
        logic [4:0] frames;    // multiframe length minus one
        logic [2:0] subclass;  // device subclass code
        logic [2:0] version;   // interface version code
        logic       soft_rst;  // link receiver held in reset
        logic       ack;       // answer strobe
        logic [7:0] rdata;     // read byte
    } jlp_dev_s;

    jlp_dev_s cur;       // registered state
    jlp_dev_s next_cur;  // next value

    // read field images, fixed and live, and the read mux result
    logic [7:0] lanes_img;     // lane count byte
    logic [7:0] cs_res_img;    // control bits and resolution
    logic [7:0] sub_np_img;    // subclass and sample bits
    logic [7:0] ver_smp_img;   // version and samples
    logic [7:0] soft_img;      // soft reset byte
    logic [7:0] read_byte;     // read mux result

    // legality of incoming writes
    logic       frames_ok;     // multiframe code accepted
    logic       subclass_ok;   // subclass code accepted
    logic       version_ok;    // version code accepted

    // read images, reserved bits read zero
    always_comb begin
        // lanes: reserved [7:5] zero, count minus one
        lanes_img = {3'h0, RST_LANES};  // RL1
        // control bits field is tied to zero
        cs_res_img = {RST_CS, 1'b0, RST_RES};  // RL6 RL7
        // subclass live, bits per sample fixed
        sub_np_img = {cur.subclass, RST_NP};  // RL8 RL9
        // version live, samples fixed
        ver_smp_img = {cur.version, RST_SAMPLES};  // RL10
        // only the soft reset bit is implemented
        soft_img = 8'h00;
        soft_img[SOFT_RESET_BIT] = cur.soft_rst;
    end

    // read decode by offset
    always_comb begin
        case (bus.reg_addr)
            // lane count
            OFS_LANES: begin
                read_byte = lanes_img;
            end
            // octets per frame, informational only
            OFS_OCTETS: begin
                read_byte = RST_OCTETS;  // RL2
            end
            // multiframe length, reserved bits zero
            OFS_FRAMES: begin
                read_byte = {3'h0, cur.frames};  // RL3
            end
            // converter count
            OFS_CONVERTERS: begin
                read_byte = RST_CONVERTERS;  // RL5
            end
            // control bits and resolution
            OFS_CS_RES: begin
                read_byte = cs_res_img;
            end
            // subclass and bits per sample
            OFS_SUB_NP: begin
                read_byte = sub_np_img;
            end
            // version and samples
            OFS_VER_SAMPLES: begin
                read_byte = ver_smp_img;
            end
            // soft reset control
            OFS_SOFT_RESET: begin
                read_byte = soft_img;
            end
            // unmapped offsets read zero
            default: begin
                read_byte = 8'h00;
            end
        endcase
    end

    // code checks on the write byte
    always_comb begin
        // only 16 or 32 frames are meaningful
        frames_ok = (bus.reg_wdata[4:0] == FRAMES_16)
                 || (bus.reg_wdata[4:0] == FRAMES_32);  // RL3
        // subclass 2 and above never reach the link
        subclass_ok = (bus.reg_wdata[7:UPPER_LSB] == SUBCLASS_0)
                   || (bus.reg_wdata[7:UPPER_LSB] == SUBCLASS_1);  // RL8
        // only the two defined revisions
        version_ok = (bus.reg_wdata[7:UPPER_LSB] == VERSION_A)
                  || (bus.reg_wdata[7:UPPER_LSB] == VERSION_B);  // RL10
    end

    // next state
    always_comb begin
        next_cur = cur;
        // answer lasts one cycle
        next_cur.ack = 1'b0;
        if (bus.reg_wr) begin
            // every write is answered, accepted or not
            next_cur.ack = 1'b1;
            next_cur.rdata = 8'h00;
            case (bus.reg_addr)
                // illegal codes keep the old value
                OFS_FRAMES: begin
                    if (frames_ok) begin
                        next_cur.frames = bus.reg_wdata[4:0];  // RL3
                    end
                end
                // subclass in the upper three bits
                OFS_SUB_NP: begin
                    if (subclass_ok) begin
                        next_cur.subclass =
                            bus.reg_wdata[7:UPPER_LSB];  // RL8
                    end
                end
                // version in the upper three bits
                OFS_VER_SAMPLES: begin
                    if (version_ok) begin
                        next_cur.version =
                            bus.reg_wdata[7:UPPER_LSB];  // RL10
                    end
                end
                // soft reset of the link receiver
                OFS_SOFT_RESET: begin
                    next_cur.soft_rst = bus.reg_wdata[SOFT_RESET_BIT];
                end
                // read-only and unmapped: write ignored
                default: begin
                end
            endcase
        end else if (bus.reg_rd) begin
            // read answered next cycle
            next_cur.ack = 1'b1;
            next_cur.rdata = read_byte;
        end
    end

    // state register
    // writable fields are trusted to change only under
    // soft reset; the controller keeps that order  RL4
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur.frames   <= RST_FRAMES;  // RL3
            cur.subclass <= RST_SUBCLASS;  // RL8
            cur.version  <= RST_VERSION;  // RL10
            // receiver starts out of soft reset
            cur.soft_rst <= 1'b0;
            cur.ack      <= 1'b0;
            cur.rdata    <= 8'h00;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state register
    assign bus.reg_ack   = cur.ack;
    assign bus.reg_rdata = cur.rdata;

    // values the receiver checks against the alignment data, and its soft reset
    assign cfg_frames_per_multiframe = cur.frames;
    assign cfg_subclass              = cur.subclass;
    assign cfg_version               = cur.version;
    assign rx_soft_reset             = cur.soft_rst;

endmodule

// >>> jlp_host.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
// axi4-lite controller driving the parameter bank
module jlp_host (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    jlp_reg_if.ctl           bus
);
    import jlp_pkg::*;

    typedef enum logic {JLP_IDLE, JLP_WAIT} jlp_host_state_e;

    // whole state of the controller
    typedef struct packed {
        jlp_host_state_e state;    // bank access state
        logic        aw_got;       // write address held
        logic [3:0]  awaddr;       // held write address
        logic        w_got;        // write data held
        logic [31:0] wdata;        // held write data
        logic [3:0]  wstrb;        // held byte enables
        logic [11:0] target;       // bank offset to access
        logic [7:0]  wbyte;        // byte to write
        logic        refused;      // sticky refusal flag
        logic        shadow_soft;  // last soft reset written
        logic [7:0]  last_rdata;   // byte from last access
        logic [11:0] reg_addr;     // bank port
        logic        reg_wr;
        logic        reg_rd;
        logic [7:0]  reg_wdata;
        logic        awready;      // axi outputs
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } jlp_host_s;

    jlp_host_s cur;       // registered state
    jlp_host_s next_cur;  // next value

    // merge a written word under its byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // a bank write is legal only for writable fields; config fields need
    // a legal code and a held receiver, soft reset is always legal
    function automatic logic allowed(input logic [11:0] ofs,
                                     input logic [7:0]  val,
                                     input logic        held);
        logic ok;
        case (ofs)
            OFS_FRAMES: begin
                ok = held && (val[4:0] == FRAMES_16
                           || val[4:0] == FRAMES_32);  // RL3 RL4
            end
            OFS_SUB_NP: begin
                ok = held && (val[7:UPPER_LSB] == SUBCLASS_0
                           || val[7:UPPER_LSB] == SUBCLASS_1);  // RL8 RL4
            end
            OFS_VER_SAMPLES: begin
                ok = held && (val[7:UPPER_LSB] == VERSION_A
                           || val[7:UPPER_LSB] == VERSION_B);  // RL10 RL4
            end
            OFS_SOFT_RESET: begin
                ok = 1'b1;
            end
            // read-only fields are never written
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // status word image
    function automatic logic [31:0] status(input jlp_host_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ST_BUSY_BIT] = (s.state == JLP_WAIT);
        w[ST_REFUSED_BIT] = s.refused;
        w[ST_RDATA_LSB +: 8] = s.last_rdata;
        return w;
    endfunction

    // next state
    always_comb begin
        logic [31:0] word;     // merged write word
        logic        ref_ev;   // refusal event this cycle
        logic        ref_clr;  // software clear this cycle
        logic        held;     // soft reset after this write
        word = 32'h0000_0000;
        ref_ev = 1'b0;
        ref_clr = 1'b0;
        held = 1'b0;
        next_cur = cur;
        // bank requests are one-cycle pulses
        next_cur.reg_wr = 1'b0;
        next_cur.reg_rd = 1'b0;
        // wait for the bank answer, however long
        if (cur.state == JLP_WAIT && bus.reg_ack) begin
            next_cur.last_rdata = bus.reg_rdata;
            next_cur.state = JLP_IDLE;
        end
        // address and data taken in either order
        if (s_axi_awvalid && cur.awready) begin
            next_cur.aw_got = 1'b1;
            next_cur.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && cur.wready) begin
            next_cur.w_got = 1'b1;
            next_cur.wdata = s_axi_wdata;
            next_cur.wstrb = s_axi_wstrb;
        end
        // both held: perform the write, answer on b
        if (cur.aw_got && cur.w_got && !cur.bvalid) begin
            next_cur.aw_got = 1'b0;
            next_cur.w_got = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp = RESP_OKAY;
            case (cur.awaddr)
                H_TARGET: begin
                    word = merge({20'h00000, cur.target},
                                 cur.wdata, cur.wstrb);
                    next_cur.target = word[11:0];
                end
                H_WDATA: begin
                    word = merge({24'h000000, cur.wbyte},
                                 cur.wdata, cur.wstrb);
                    next_cur.wbyte = word[7:0];
                end
                H_GO: begin
                    // start lane not enabled: ignored; busy: refused
                    if (!cur.wstrb[0]) begin
                    end else if (cur.state != JLP_IDLE) begin
                        ref_ev = cur.wdata[GO_WR_BIT]
                              || cur.wdata[GO_RD_BIT];
                    end else if (cur.wdata[GO_WR_BIT]) begin
                        if (cur.target == OFS_SOFT_RESET) begin
                            held = cur.wbyte[SOFT_RESET_BIT];
                        end else begin
                            held = cur.shadow_soft;
                        end
                        if (allowed(cur.target, cur.wbyte,
                                    cur.shadow_soft)) begin  // RL4
                            next_cur.shadow_soft = held;
                            next_cur.reg_addr = cur.target;
                            next_cur.reg_wdata = cur.wbyte;
                            next_cur.reg_wr = 1'b1;
                            next_cur.state = JLP_WAIT;
                        end else begin
                            ref_ev = 1'b1;
                        end
                    end else if (cur.wdata[GO_RD_BIT]) begin
                        next_cur.reg_addr = cur.target;
                        next_cur.reg_rd = 1'b1;
                        next_cur.state = JLP_WAIT;
                    end
                end
                H_STATUS: begin
                    // write one clears the refusal flag
                    ref_clr = cur.wstrb[0]
                           && cur.wdata[ST_REFUSED_BIT];
                end
                default: begin
                    next_cur.bresp = RESP_SLVERR;
                end
            endcase
        end
        // a refusal in the clearing cycle is kept
        next_cur.refused = (cur.refused && !ref_clr) || ref_ev;
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
        end
        // read channel
        if (s_axi_arvalid && cur.arready) begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp = RESP_OKAY;
            case (s_axi_araddr)
                H_TARGET: next_cur.rdata = {20'h00000, cur.target};
                H_WDATA:  next_cur.rdata = {24'h000000, cur.wbyte};
                H_GO:     next_cur.rdata = 32'h0000_0000;
                H_STATUS: next_cur.rdata = status(cur);
                default: begin
                    next_cur.rdata = 32'h0000_0000;
                    next_cur.rresp = RESP_SLVERR;
                end
            endcase
        end else if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
        end
        // readies from the state being entered
        next_cur.awready = !next_cur.aw_got && !next_cur.bvalid;
        next_cur.wready = !next_cur.w_got && !next_cur.bvalid;
        next_cur.arready = !next_cur.rvalid;
    end

    // state register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
            cur.state <= JLP_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = cur.awready;
    assign s_axi_wready  = cur.wready;
    assign s_axi_bvalid  = cur.bvalid;
    assign s_axi_bresp   = cur.bresp;
    assign s_axi_arready = cur.arready;
    assign s_axi_rvalid  = cur.rvalid;
    assign s_axi_rdata   = cur.rdata;
    assign s_axi_rresp   = cur.rresp;
    assign bus.reg_addr  = cur.reg_addr;
    assign bus.reg_wr    = cur.reg_wr;
    assign bus.reg_rd    = cur.reg_rd;
    assign bus.reg_wdata = cur.reg_wdata;

endmodule

// >>> jlp_pkg.sv
// Summary of operation
// (RL1) lane count minus one, read-only, resets 0x7
// (RL2) octets per frame minus one, read-only, zero
// (RL3) frames per multiframe minus one; 16/32 codes
// (RL4) program config fields only during soft reset
// (RL5) converter count minus one, read-only, 0x1
// (RL6) control bits per sample always read zero
// (RL7) resolution 16 coded 0x0f, read-only
// (RL8) subclass 0 or 1 only, resets 0
// (RL9) bits per sample 16 coded 0x0f, read-only
// (RL10) version 000 original, 001 B, writable
package jlp_pkg;

    // link parameter register offsets
    localparam logic [11:0] OFS_LANES       = 12'h453;
    localparam logic [11:0] OFS_OCTETS      = 12'h454;
    localparam logic [11:0] OFS_FRAMES      = 12'h455;
    localparam logic [11:0] OFS_CONVERTERS  = 12'h456;
    localparam logic [11:0] OFS_CS_RES      = 12'h457;
    localparam logic [11:0] OFS_SUB_NP      = 12'h458;
    localparam logic [11:0] OFS_VER_SAMPLES = 12'h459;
    localparam logic [11:0] OFS_SOFT_RESET  = 12'h475;

    // field positions
    localparam int SOFT_RESET_BIT = 3;
    localparam int UPPER_LSB      = 5;

    // reset values
    localparam logic [4:0] RST_LANES      = 5'h07;
    localparam logic [7:0] RST_OCTETS     = 8'h00;
    localparam logic [4:0] RST_FRAMES     = 5'h1f;
    localparam logic [7:0] RST_CONVERTERS = 8'h01;
    localparam logic [1:0] RST_CS         = 2'h0;
    localparam logic [4:0] RST_RES        = 5'h0f;
    localparam logic [2:0] RST_SUBCLASS   = 3'h0;
    localparam logic [4:0] RST_NP         = 5'h0f;
    localparam logic [2:0] RST_VERSION    = 3'h0;
    localparam logic [4:0] RST_SAMPLES    = 5'h01;

    // legal codes of the writable fields
    localparam logic [4:0] FRAMES_16  = 5'h0f;
    localparam logic [4:0] FRAMES_32  = 5'h1f;
    localparam logic [2:0] SUBCLASS_0 = 3'h0;
    localparam logic [2:0] SUBCLASS_1 = 3'h1;
    localparam logic [2:0] VERSION_A  = 3'h0;
    localparam logic [2:0] VERSION_B  = 3'h1;

    // controller registers, byte addresses on axi4-lite
    localparam logic [3:0] H_TARGET = 4'h0;
    localparam logic [3:0] H_WDATA  = 4'h4;
    localparam logic [3:0] H_GO     = 4'h8;
    localparam logic [3:0] H_STATUS = 4'hc;
    localparam int GO_WR_BIT      = 0;
    localparam int GO_RD_BIT      = 1;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_RDATA_LSB   = 8;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> jlp_reg_if.sv
`timescale 1ns/100ps
// register port between controller and parameter bank
interface jlp_reg_if;
    logic [11:0] reg_addr;   // register offset
    logic        reg_wr;     // one-cycle write request
    logic        reg_rd;     // one-cycle read request
    logic [7:0]  reg_wdata;  // write byte
    logic [7:0]  reg_rdata;  // read byte, valid with ack
    logic        reg_ack;    // one-cycle answer

    modport dev (
        input  reg_addr,
        input  reg_wr,
        input  reg_rd,
        input  reg_wdata,
        output reg_rdata,
        output reg_ack
    );

    modport ctl (
        output reg_addr,
        output reg_wr,
        output reg_rd,
        output reg_wdata,
        input  reg_rdata,
        input  reg_ack
    );
endinterface

// >>> jlp_reg_sva.sv
`timescale 1ns/100ps
// register port checker
module jlp_reg_sva (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_ack
);
    import jlp_pkg::*;
    // one domain: clock and reset once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // one-cycle answer pulse
    property p_ack; (reg_wr || reg_rd) |=> reg_ack ##1 !reg_ack; endproperty
    a_ack: assert property (p_ack) else $error("bank answer late");
    // lane count fixed, upper bits zero
    property p_lanes; reg_rd && reg_addr == OFS_LANES |=> reg_rdata == 8'h07;
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane count");
    property p_octets; reg_rd && reg_addr == OFS_OCTETS |=> reg_rdata == 8'h00;
    endproperty
    a_octets: assert property (p_octets) else $error("octets");
    // only the 16 and 32 frame codes
    property p_frames; reg_rd && reg_addr == OFS_FRAMES |=>
        reg_rdata inside {8'h0f, 8'h1f}; endproperty
    a_frames: assert property (p_frames) else $error("frames code");
    property p_conv; reg_rd && reg_addr == OFS_CONVERTERS |=>
        reg_rdata == 8'h01; endproperty
    a_conv: assert property (p_conv) else $error("converters");
    // cs zero, resolution 16
    property p_cs_res; reg_rd && reg_addr == OFS_CS_RES |=>
        reg_rdata == 8'h0f; endproperty
    a_cs_res: assert property (p_cs_res) else $error("cs/res");
    property p_sub_np; reg_rd && reg_addr == OFS_SUB_NP |=>
        reg_rdata[4:0] == 5'h0f && reg_rdata[7:5] inside {3'h0, 3'h1};
    endproperty
    a_sub_np: assert property (p_sub_np) else $error("sub/np");
    property p_ver; reg_rd && reg_addr == OFS_VER_SAMPLES |=>
        reg_rdata[7:5] inside {3'h0, 3'h1}; endproperty
    a_ver: assert property (p_ver) else $error("version code");

    // main scenarios seen
    c_wr: cover property (reg_wr && reg_addr == OFS_FRAMES);
    c_sr: cover property (reg_wr && reg_addr == OFS_SOFT_RESET);
    c_rd: cover property (reg_rd ##1 reg_ack);
endmodule
